/* design/mem_cycle_ctrl.sv */
// Memory controller end: clock phases, DRAM cycle choice, strobes and abort.
`timescale 1ns/1ps
`default_nettype none
module mem_cycle_ctrl #(
   parameter logic [15:0] PAGE_MAP = cycle_pkg::PAGE_MAP_DEF  // Mapped logical pages.
) (
   input wire logic clk,                                  // Master clock, 200 MHz.
   input wire logic nrst,                                 // Asynchronous reset, active low.
   cpu_bus_if.ctrl bus,                                   // Processor side.
   output logic ras_n,                                    // DRAM row strobe, active low.
   output logic [cycle_pkg::LANES-1:0] cas_n,             // DRAM column strobes, active low.
   output logic dram_we_n,                                // DRAM write enable, active low.
   output logic [cycle_pkg::ADDR_W-1:0] phys_address,     // Translated address of the cycle.
   output logic cycle_start                               // One-cycle pulse per processor cycle.
);
   // ****************************************************************
   // Clock division
   // ****************************************************************
   logic [1:0] div_reg;     // Divider slot counter.
   logic [1:0] div_next;    // Next divider slot.
   logic ph1_reg;           // Phase one output flop.
   logic ph2_reg;           // Phase two output flop.
   logic cyc_end;           // Last master cycle of a processor cycle.

   // Sequencing state.
   cycle_pkg::dram_state_t state_reg;
   cycle_pkg::dram_state_t state_next;
   logic write_reg;         // Current cycle is a write.
   logic abort_reg;         // Current cycle is aborted.
   logic [cycle_pkg::LANES-1:0] lane_reg;  // Lanes enabled for the current cycle.
   logic [cycle_pkg::ADDR_W-1:0] addr_reg; // Translated address of the current cycle.
   logic [cycle_pkg::ADDR_W-1:0] addr_next;
   logic active_reg;        // Current processor cycle is an access.
   logic internal_reg;      // Current processor cycle is internal.
   logic early_reg;         // Random cycle started early inside an internal cycle.
   logic seq_reg;           // Captured access continues the open page.
   logic [cycle_pkg::LANES-1:0] col_lane_reg;  // Lanes of the column phase.
   logic col_write_reg;     // Column phase writes memory.
   logic col_block_reg;     // Column phase belongs to an aborted write.
   logic deny;              // Access violates protection or map.

   // Lane decode, shared by byte and word requests.
   function automatic logic [cycle_pkg::LANES-1:0] lane_decode(
      input logic byte_n, input logic [1:0] low_bits);
      logic [cycle_pkg::LANES-1:0] lanes;
      lanes = '0;
      if (byte_n) begin
         lanes = '1;  // Word: all lanes, low bits ignored.
      end else begin
         lanes[low_bits] = 1'b1;  // Byte lane from the two low bits.
      end
      return lanes;
   endfunction : lane_decode

   // Divider: three slots give phase one, a gap, then phase two.
   always_comb begin
      div_next = (div_reg == 2'(cycle_pkg::CLK_DIV - 1)) ? cycle_pkg::DIV_RESET
                                                          : div_reg + 2'h1;
   end
   assign cyc_end = (div_reg == 2'(cycle_pkg::CLK_DIV - 1));
   assign cycle_start = cyc_end;

   // Slot counter.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         div_reg <= cycle_pkg::DIV_RESET;
      end else begin
         div_reg <= div_next;
      end
   end

   // Phases are registered from the next slot so they never overlap or glitch.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ph1_reg <= 1'b0;
         ph2_reg <= 1'b0;
      end else begin
         ph1_reg <= (div_next == cycle_pkg::PH1_SLOT);
         ph2_reg <= (div_next == cycle_pkg::PH2_SLOT);
      end
   end
   assign bus.phase1 = ph1_reg;
   assign bus.phase2 = ph2_reg;
   assign bus.ref_clock = ph2_reg;  // Same flop, so the two can never skew.

   // ****************************************************************
   // Address check and translation
   // ****************************************************************
   // Protection and map check on the address the processor presents now.
   always_comb begin
      logic [3:0] page;
      page = bus.cpu_address_bus[cycle_pkg::PAGE_MSB:cycle_pkg::PAGE_LSB];
      deny = 1'b0;
      if (!bus.supervisor_select && page >= cycle_pkg::PROT_PAGE) begin
         deny = 1'b1;  // User mode touching supervisor space.
      end else if (!PAGE_MAP[page]) begin
         deny = 1'b1;  // Logical page with no mapping.
      end
   end

   // Remap only user-mode transfers; aligned words drop the low bits.
   always_comb begin
      addr_next = bus.cpu_address_bus;
      if (bus.byte_not_word_n) begin
         addr_next[1:0] = 2'h0;
      end
      if (!bus.supervisor_select) begin
         addr_next[cycle_pkg::PAGE_MSB:cycle_pkg::PAGE_LSB] =
            addr_next[cycle_pkg::PAGE_MSB:cycle_pkg::PAGE_LSB] + cycle_pkg::REMAP_PAGE;
      end
   end

   // ****************************************************************
   // Cycle capture
   // ****************************************************************
   // Pipelined controls are taken at the end of the cycle before the one they govern.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         active_reg <= 1'b0;
         internal_reg <= 1'b1;
         write_reg <= 1'b0;
         abort_reg <= 1'b0;
         lane_reg <= '0;
         addr_reg <= '0;
         seq_reg <= 1'b0;
      end else if (cyc_end) begin
         active_reg <= !bus.memory_request_n;
         seq_reg <= !bus.memory_request_n && bus.sequential_access;
         internal_reg <= bus.memory_request_n;
         write_reg <= !bus.memory_request_n && bus.read_not_write_n;
         abort_reg <= !bus.memory_request_n && deny;
         lane_reg <= lane_decode(bus.byte_not_word_n, bus.cpu_address_bus[1:0]);
         addr_reg <= addr_next;
      end
   end
   assign phys_address = addr_reg;
   assign bus.abort_out = abort_reg;
   assign bus.data_bus_enable = write_reg && active_reg;

   // The column phase runs one processor cycle behind the capture, so it keeps its own copy.
   // Without it the strobes would carry the attributes of the next request.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         col_lane_reg <= '0;
         col_write_reg <= 1'b0;
         col_block_reg <= 1'b0;
      end else if (cyc_end) begin
         col_lane_reg <= lane_reg;
         col_write_reg <= write_reg && !abort_reg;
         col_block_reg <= write_reg && abort_reg;
      end
   end
   assign dram_we_n = !col_write_reg;

   // ****************************************************************
   // DRAM strobe sequencing
   // ****************************************************************
   // Early random start when a request with sequential flag arrives during an internal cycle.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         early_reg <= 1'b0;
      end else if (cyc_end) begin
         early_reg <= 1'b0;
      end else if (internal_reg && !bus.memory_request_n && bus.sequential_access) begin
         early_reg <= 1'b1;
      end
   end

   // State choice at each processor cycle boundary, except the early row start from idle, which is taken at once.
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         cycle_pkg::ST_IDLE: begin
            if (early_reg) begin
               state_next = cycle_pkg::ST_RAS;  // Row opened inside the internal cycle.
            end
         end
         cycle_pkg::ST_RAS: begin
            // An early row stays open until its own access has been captured.
            if (cyc_end && !early_reg) begin
               state_next = cycle_pkg::ST_CAS;
            end
         end
         cycle_pkg::ST_CAS: begin
            // The next column serves the access captured one cycle ago.
            if (cyc_end) begin
               if (!active_reg) begin
                  state_next = cycle_pkg::ST_PRECHARGE;
               end else if (seq_reg) begin
                  state_next = cycle_pkg::ST_CAS;  // Page mode, row stays open.
               end else begin
                  state_next = cycle_pkg::ST_PRECHARGE;  // Random: release both.
               end
            end
         end
         cycle_pkg::ST_PRECHARGE: begin
            if (cyc_end) begin
               state_next = (!bus.memory_request_n || early_reg) ? cycle_pkg::ST_RAS
                                                                 : cycle_pkg::ST_IDLE;
            end
         end
         default: begin
            state_next = cycle_pkg::ST_IDLE;
         end
      endcase
      if (state_reg == cycle_pkg::ST_IDLE && cyc_end && !bus.memory_request_n) begin
         state_next = cycle_pkg::ST_RAS;  // Fresh request from idle is random.
      end
   end

   // State register.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= cycle_pkg::ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Strobes are registered; column strobe is released for one slot at each cycle end.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ras_n <= 1'b1;
         cas_n <= '1;
      end else begin
         ras_n <= !(state_next == cycle_pkg::ST_RAS || state_next == cycle_pkg::ST_CAS);
         if (state_next == cycle_pkg::ST_CAS && !cyc_end && !col_block_reg) begin
            cas_n <= ~col_lane_reg;
         end else begin
            cas_n <= '1;  // Released for new column or precharge.
         end
      end
   end
endmodule : mem_cycle_ctrl
`default_nettype wire

/* design/cycle_pkg.sv */
// Package of shared constants and types for the processor memory cycle interface.
`default_nettype none
package cycle_pkg;
   // ****************************************************************
   // Widths and clock division
   // ****************************************************************
   localparam int ADDR_W = 26;            // Processor address width.
   localparam int DATA_W = 32;            // Data word width.
   localparam int LANES = 4;              // Byte lanes per word.
   localparam int CLK_DIV = 3;            // Master clock cycles per processor cycle.
   localparam logic [1:0] DIV_RESET = 2'h0;   // Divider phase after reset.
   localparam logic [1:0] PH1_SLOT = 2'h0;    // Divider slot with phase one high.
   localparam logic [1:0] PH2_SLOT = 2'h2;    // Divider slot with phase two high.
   localparam logic [ADDR_W-1:0] SEQ_STEP = 26'h0000004;  // Sequential address increment.
   localparam int SEQ_LSB = 2;            // Lowest address bit of the sequential boundary.
   localparam int SEQ_MSB = 3;            // Highest address bit of the sequential boundary.
   // ****************************************************************
   // Memory map and protection
   // ****************************************************************
   localparam int PAGE_MSB = 25;          // Top bit of the logical page number.
   localparam int PAGE_LSB = 22;          // Bottom bit of the logical page number.
   localparam logic [3:0] PROT_PAGE = 4'hC;   // Page from which supervisor space begins.
   localparam logic [15:0] PAGE_MAP_DEF = 16'h00FF;  // Default set of mapped logical pages.
   localparam logic [3:0] REMAP_PAGE = 4'h1;  // Page offset added by user-mode remapping.

   // DRAM cycle sequencing states.
   typedef enum logic [2:0] {
      ST_IDLE,       // Row strobe released, no access in flight.
      ST_RAS,        // First half of a random cycle: row open.
      ST_CAS,        // Column strobe active for the transfer.
      ST_PRECHARGE   // Both strobes released for precharge.
   } dram_state_t;
endpackage : cycle_pkg
`default_nettype wire

/* design/cpu_bus_if.sv */
// Interface joining the processor end and the memory controller end.
`timescale 1ns/1ps
`default_nettype none
interface cpu_bus_if;
   logic [cycle_pkg::ADDR_W-1:0] cpu_address_bus;  // Address of the coming cycle.
   logic read_not_write_n;                         // Low read, high write.
   logic byte_not_word_n;                          // Low byte, high word.
   logic memory_request_n;                         // Low: next cycle accesses memory.
   logic sequential_access;                        // High: next address is current plus four.
   logic supervisor_select;                        // Low: user mode, restricted.
   logic phase1;                                   // Processor clock phase one.
   logic phase2;                                   // Processor clock phase two.
   logic ref_clock;                                // Bus reference clock, in phase with phase two.
   logic data_bus_enable;                          // High: processor drives data bus.
   logic abort_out;                                // High: current cycle aborted.

   modport ctrl (
      input cpu_address_bus, read_not_write_n, byte_not_word_n, memory_request_n,
      input sequential_access, supervisor_select,
      output phase1, phase2, ref_clock, data_bus_enable, abort_out
   );
   modport cpu (
      output cpu_address_bus, read_not_write_n, byte_not_word_n, memory_request_n,
      output sequential_access, supervisor_select,
      input phase1, phase2, ref_clock, data_bus_enable, abort_out
   );
endinterface : cpu_bus_if
`default_nettype wire

/* design/cpu_bus_master.sv */
// Processor end: presents pipelined cycle requests on the controller's clock phases.
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_master (
   input wire logic clk,                                  // Master clock, 200 MHz.
   input wire logic nrst,                                 // Asynchronous reset, active low.
   cpu_bus_if.cpu bus,                                    // Controller side.
   input wire logic req_valid,                            // User asks for a memory cycle.
   input wire logic [cycle_pkg::ADDR_W-1:0] req_address,  // Address of the request.
   input wire logic req_write,                            // High for a write.
   input wire logic req_byte,                             // High for a byte transfer.
   input wire logic req_user,                             // High for user-mode access.
   output logic req_taken,                                // Pulse when the request is issued.
   output logic aborted                                   // Pulse when a cycle was aborted.
);
   // ****************************************************************
   // Phase edge detection
   // ****************************************************************
   logic ph2_d_reg;   // Phase two one clock late.
   logic ph2_rise;    // Phase two rising edge.
   logic [cycle_pkg::ADDR_W-1:0] addr_reg;  // Address driven on the bus.
   logic valid_reg;   // Bus carries a request.

   // Phase two shares our clock, so no synchroniser is needed.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ph2_d_reg <= 1'b0;
      end else begin
         ph2_d_reg <= bus.phase2;
      end
   end
   assign ph2_rise = bus.phase2 && !ph2_d_reg;
   assign req_taken = ph2_rise && req_valid;

   // New address and controls only once phase two has risen.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         addr_reg <= '0;
         valid_reg <= 1'b0;
         bus.read_not_write_n <= 1'b0;
         bus.byte_not_word_n <= 1'b1;
         bus.supervisor_select <= 1'b1;
         bus.sequential_access <= 1'b0;
      end else if (ph2_rise) begin
         addr_reg <= req_address;
         valid_reg <= req_valid;
         bus.read_not_write_n <= req_write;
         bus.byte_not_word_n <= !req_byte;
         bus.supervisor_select <= !req_user;
         bus.sequential_access <= req_valid && valid_reg
                                  && (req_address == addr_reg + cycle_pkg::SEQ_STEP);
      end
   end
   assign bus.cpu_address_bus = addr_reg;
   assign bus.memory_request_n = !valid_reg;

   // Abort shows while phase two is high; report it once.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         aborted <= 1'b0;
      end else begin
         aborted <= ph2_rise && bus.abort_out;
      end
   end
endmodule : cpu_bus_master
`default_nettype wire

/* verification/cycle_bus_props.sv */
// Checker of the processor bus between the processor end and the memory controller end.
`timescale 1ns/1ps
`default_nettype none
module cycle_bus_props #(
   parameter logic [15:0] PAGE_MAP = cycle_pkg::PAGE_MAP_DEF  // Mapped logical pages.
) (
   input wire logic clk,                                   // Master clock.
   input wire logic nrst,                                  // Asynchronous reset, active low.
   input wire logic [cycle_pkg::ADDR_W-1:0] cpu_address_bus,  // Address of the coming cycle.
   input wire logic read_not_write_n,                      // High for a write.
   input wire logic memory_request_n,                      // Low for an access.
   input wire logic sequential_access,                     // High for address plus four.
   input wire logic supervisor_select,                     // Low in user mode.
   input wire logic phase1,                                // Clock phase one.
   input wire logic phase2,                                // Clock phase two.
   input wire logic ref_clock,                             // Bus reference clock.
   input wire logic data_bus_enable,                       // Processor drives data.
   input wire logic abort_out                              // Cycle aborted.
);
   // ****************************************************************
   // Controls captured at the edge that ends the phase two slot
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   logic ok_reg;             // A capture has been made since reset.
   logic wr_reg;             // Captured direction.
   logic req_n_reg;          // Captured request, low for an access.
   logic user_reg;           // Captured user mode.
   logic [3:0] page_reg;     // Captured logical page.
   logic bad_access;         // Captured access must be aborted.
   // The capture waits for the first phase two so that reset values never count as a request.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ok_reg <= 1'b0;
         wr_reg <= 1'b0;
         req_n_reg <= 1'b1;
         user_reg <= 1'b0;
         page_reg <= 4'h0;
      end else if (phase2) begin
         ok_reg <= 1'b1;
         wr_reg <= read_not_write_n;
         req_n_reg <= memory_request_n;
         user_reg <= !supervisor_select;
         page_reg <= cpu_address_bus[cycle_pkg::PAGE_MSB:cycle_pkg::PAGE_LSB];
      end
   end
   assign bad_access = (user_reg && page_reg >= cycle_pkg::PROT_PAGE) || !PAGE_MAP[page_reg];
   // ****************************************************************
   // Sequences and assertions
   // ****************************************************************
   // The middle slot of a processor cycle, when every answer has settled.
   sequence slot_one;
      $past(phase1) && !phase1 && !phase2;
   endsequence
   // Two quiet slots, then phase one again.
   sequence ph1_gap;
      !phase1 [*2] ##1 phase1;
   endsequence
   a_phase_apart: assert property (!(phase1 && phase2))
      else $error("clock phases overlap");
   a_ref_tracks_ph2: assert property (ref_clock == phase2)
      else $error("reference clock differs from phase two");
   a_phase_period: assert property ($rose(phase1) |=> ph1_gap)
      else $error("phase one period is not three clocks");
   a_ph2_slot: assert property ($rose(phase1) |-> ##2 phase2 ##1 !phase2)
      else $error("phase two not in the third slot");
   a_abort_value: assert property (slot_one ##0 (ok_reg && !req_n_reg) |-> abort_out == bad_access)
      else $error("abort does not match the access");
   a_idle_quiet: assert property (slot_one ##0 (ok_reg && req_n_reg) |-> !abort_out && !data_bus_enable)
      else $error("internal cycle shows activity");
   a_dbe_write: assert property (slot_one ##0 (ok_reg && !req_n_reg && !bad_access) |-> data_bus_enable == wr_reg)
      else $error("bus enable does not follow direction");
   a_abort_stands: assert property ($rose(abort_out) |=> abort_out [*2])
      else $error("abort shorter than a processor cycle");
   a_dbe_stands: assert property ($rose(data_bus_enable) |=> data_bus_enable [*2])
      else $error("bus enable shorter than a processor cycle");
   a_addr_hold: assert property ($changed(cpu_address_bus) |-> phase2 || $past(phase2))
      else $error("address changed away from phase two");
   a_seq_step: assert property ($changed(cpu_address_bus) && sequential_access && !memory_request_n
      |-> cpu_address_bus == $past(cpu_address_bus) + cycle_pkg::SEQ_STEP)
      else $error("sequential flag without an increment of four");
endmodule : cycle_bus_props
`default_nettype wire

/* verification/processor_memory_cycle_interface_test.sv */
// Testbench joining the processor end and the memory controller end.
`timescale 1ns/1ps
`default_nettype none
module processor_memory_cycle_interface_test;
   // ****************************************************************
   // Clock, reset and the two ends
   // ****************************************************************
   logic clk = 1'b0;                                  // Master clock, 5 ns period.
   logic nrst = 1'b0;                                 // Reset, active low.
   logic req_valid = 1'b0;                            // Request strobe to the processor end.
   logic [cycle_pkg::ADDR_W-1:0] req_address = '0;    // Request address.
   logic req_write = 1'b0;                            // Request direction.
   logic req_byte = 1'b0;                             // Request size.
   logic req_user = 1'b0;                             // Request mode.
   logic req_taken;                                   // Request issued.
   logic aborted;                                     // Cycle aborted.
   logic ras_n;                                       // Row strobe.
   logic [cycle_pkg::LANES-1:0] cas_n;                // Column strobes.
   logic dram_we_n;                                   // Write enable.
   logic [cycle_pkg::ADDR_W-1:0] phys_address;        // Translated address.
   int n_mismatch = 0;                                // Mismatches seen.
   int n_checks = 0;                                  // Comparisons made.
   int ras_rises = 0;                                 // Row strobe releases so far.
   logic board_we_n;                                  // Board write enable from the bus enable.
   cpu_bus_if u_cpu_bus_if ();
   assign board_we_n = !u_cpu_bus_if.data_bus_enable;  // Board inverter.
   mem_cycle_ctrl u_mem_cycle_ctrl (.clk(clk), .nrst(nrst), .bus(u_cpu_bus_if), .ras_n(ras_n),
      .cas_n(cas_n), .dram_we_n(dram_we_n), .phys_address(phys_address), .cycle_start());
   cpu_bus_master u_cpu_bus_master (.clk(clk), .nrst(nrst), .bus(u_cpu_bus_if),
      .req_valid(req_valid), .req_address(req_address), .req_write(req_write),
      .req_byte(req_byte), .req_user(req_user), .req_taken(req_taken), .aborted(aborted));
   cycle_bus_props u_cycle_bus_props (.clk(clk), .nrst(nrst),
      .cpu_address_bus(u_cpu_bus_if.cpu_address_bus),
      .read_not_write_n(u_cpu_bus_if.read_not_write_n),
      .memory_request_n(u_cpu_bus_if.memory_request_n),
      .sequential_access(u_cpu_bus_if.sequential_access),
      .supervisor_select(u_cpu_bus_if.supervisor_select), .phase1(u_cpu_bus_if.phase1),
      .phase2(u_cpu_bus_if.phase2), .ref_clock(u_cpu_bus_if.ref_clock),
      .data_bus_enable(u_cpu_bus_if.data_bus_enable), .abort_out(u_cpu_bus_if.abort_out));
   // Free-running master clock.
   initial begin
      forever #2.5 clk = ~clk;
   end
   // Counts row strobe releases; tests look only at differences.
   always @(posedge ras_n) begin
      ras_rises <= ras_rises + 1;
   end
   // ****************************************************************
   // Tasks
   // ****************************************************************
   // Prints counts and verdict, then ends the run.
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop
   // Compares one value and reports a difference at once.
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // Waits, bounded, until the processor end issues the pending request.
   task automatic wait_taken();
      int i;
      for (i = 0; i < 24; i++) begin
         @(posedge clk);
         #1;
         if (req_taken === 1'b1) break;
      end
      if (i == 24) begin
         n_mismatch++;
         $display("[FAIL] req_taken expected 1 seen 0");
         report_and_stop();
      end
   endtask : wait_taken
   // One isolated access, then a watch over the whole DRAM cycle.
   task automatic one_access(input logic [25:0] a, input logic wr, input logic by,
      input logic usr, input logic bad);
      logic ab;
      logic we;
      logic [3:0] lanes;
      logic [25:0] pa;
      logic dbe;
      ab = 1'b0;
      we = 1'b0;
      lanes = 4'h0;
      pa = '0;
      dbe = 1'b0;
      @(posedge clk);
      req_valid <= 1'b1;
      req_address <= a;
      req_write <= wr;
      req_byte <= by;
      req_user <= usr;
      wait_taken();
      @(posedge clk);
      req_valid <= 1'b0;
      for (int i = 0; i < 12; i++) begin
         @(posedge clk);
         #1;
         ab = ab | aborted;
         we = we | ~dram_we_n;
         lanes = lanes | ~cas_n;
         dbe = dbe | ~board_we_n;
         if (i == 2) pa = phys_address;  // Just after the controller's capture.
      end
      check("aborted", bad, ab);
      check("write enable", wr & ~bad, we);
      check("board write enable", wr, dbe);
      // An aborted read may still strobe; only writes must stay silent.
      if (!bad || wr) check("lanes", bad ? 4'h0 : (by ? 4'h1 << a[1:0] : 4'hF), lanes);
      if (!bad) check("phys page", a[25:22] + (usr ? cycle_pkg::REMAP_PAGE : 4'h0), pa[25:22]);
      if (!bad) check("phys offset", a[21:2], pa[21:2]);
      if (!bad) check("phys low bits", by ? a[1:0] : 2'h0, pa[1:0]);
      $display("access %h done", a);
   endtask : one_access
   // Four back-to-back reads; a step of four must keep the row open.
   task automatic burst(input logic [25:0] base, input logic [25:0] step, input logic any);
      int r0;
      r0 = 0;
      @(posedge clk);
      req_valid <= 1'b1;
      req_write <= 1'b0;
      req_byte <= 1'b0;
      req_user <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         req_address <= base + step * 26'(k);
         wait_taken();
         if (k == 0) r0 = ras_rises;
         @(posedge clk);
      end
      req_valid <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check("row released in burst", any, (ras_rises - r0) != 0);
      repeat (12) @(posedge clk);
      $display("burst step %h done", step);
   endtask : burst
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      repeat (12) @(posedge clk);
      #1;
      check("idle row strobe", 1'b1, ras_n);
      check("idle write enable", 1'b1, dram_we_n);
      one_access(26'h0000104, 1'b0, 1'b0, 1'b0, 1'b0);
      one_access(26'h0400002, 1'b1, 1'b0, 1'b0, 1'b0);
      one_access(26'h0000003, 1'b1, 1'b1, 1'b1, 1'b0);
      one_access(26'h0400001, 1'b0, 1'b1, 1'b1, 1'b0);
      one_access(26'h1C00005, 1'b1, 1'b1, 1'b0, 1'b0);
      one_access(26'h3000000, 1'b0, 1'b0, 1'b1, 1'b1);
      one_access(26'h2400000, 1'b1, 1'b0, 1'b1, 1'b1);
      one_access(26'h2000000, 1'b0, 1'b0, 1'b0, 1'b1);
      burst(26'h0000200, 26'h0000004, 1'b0);
      burst(26'h0000400, 26'h0000100, 1'b1);
      report_and_stop();
   end
endmodule : processor_memory_cycle_interface_test
`default_nettype wire
